// *** rtl/external_bus_pin_select_consts.vh ***
`ifndef EXTERNAL_BUS_PIN_SELECT_CONSTS_VH
`define EXTERNAL_BUS_PIN_SELECT_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets, masks and reset values
// ----------------------------------------------------------------------
`define BUS_PIN_SELECTION_OFS   16'h1C00
`define SLEW_RATE_CONTROL_OFS   16'h1C16
`define BUS_PIN_SELECTION_MASK  16'h7F3F
`define SLEW_RATE_CONTROL_MASK  16'h0005
`define BUS_PIN_SELECTION_RST   16'h0000
`define SLEW_RATE_CONTROL_RST   16'h0005

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PP_SEL_MSB              14
`define PP_SEL_LSB              12
`define SP1_SEL_MSB             11
`define SP1_SEL_LSB             10
`define SP0_SEL_MSB             9
`define SP0_SEL_LSB             8
`define ADDR_SEL_MSB            5
`define ADDR_SEL_LSB            0
`define CLOCK_OUTPUT_PIN_SLEW_BIT         2
`define EXTERNAL_MEMORY_INTERFACE_SLEW_BIT           0

// ----------------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------------
`define PP_MODE1                3'h1
`define PP_MODE2                3'h2
`define PP_MODE3                3'h3
`define PP_MODE4                3'h4
`define PP_MODE5                3'h5
`define PP_MODE6                3'h6
`define SP_MODE0                2'h0
`define SP_MODE1                2'h1
`define SP_MODE2                2'h2

// ----------------------------------------------------------------------
// Source indices into the combined peripheral signal vector
// ----------------------------------------------------------------------
`define SRC_GP                  7'h00
`define SRC_SPI                 7'h20
`define SRC_I2S0                7'h27
`define SRC_I2S1                7'h2B
`define SRC_I2S2                7'h2F
`define SRC_I2S3                7'h33
`define SRC_UART                7'h37
`define SRC_MMC0                7'h3B
`define SRC_MMC1                7'h41
`define SRC_EXTERNAL_MEMORY_INTERFACE                7'h47
`define SRC_NONE                7'h7F
`define SRC_N                   77
`define SRC_IN_N                71

// ----------------------------------------------------------------------
// Pad indices
// ----------------------------------------------------------------------
`define PAD_PP                  0
`define PAD_SP0                 21
`define PAD_SP1                 27
`define PAD_ADDR                33
`define PAD_N                   39

`endif

// *** rtl/external_bus_pin_select.v ***
`timescale 1ns/1ps
`include "external_bus_pin_select_consts.vh"

// Behaviour
// - Parallel-port select at bits 14:12; codes 000 and 111 route nothing.
// - Code 001 routes SPI seven, GPIO six, UART four, second I2S four.
// - Code 010 routes eight GPIO signals and no serial peripheral.
// - Code 011 routes four SPI signals and four third-I2S signals.
// - Code 100 routes four second-I2S signals and four UART signals.
// - Code 101 routes four SPI signals and four UART signals.
// - Code 110 routes SPI seven, second and third I2S, six GPIO.
// - Serial-1 select bits 11:10: MMC1, I2S1 plus GP11:10, GP11:6, reserved.
// - Serial-0 select bits 9:8: MMC0, I2S0 plus GP5:4, GP5:0, reserved.
// - Bit 5 turns address pin 20 into GPIO 26.
// - Bit 4 turns address pin 19 into GPIO 25.
// - Bit 3 turns address pin 18 into GPIO 24.
// - Bit 2 turns address pin 17 into GPIO 23.
// - Bit 1 turns address pin 16 into GPIO 22.
// - Bit 0 turns address pin 15 into GPIO 21.
// - Slew bit 2 drives clock-output pad slew; resets to one.
// - Slew bit 0 drives external-memory pad slew; resets to one.
// - A changed selection takes effect on the following clock cycle.
module external_bus_pin_select (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire [15:0] bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output wire [15:0] bus_rdata,
  input  wire [31:0] gp_out,
  input  wire [31:0] gp_oe,
  output wire [31:0] gp_in,
  input  wire [6:0]  spi_out,
  input  wire [6:0]  spi_oe,
  output wire [6:0]  spi_in,
  input  wire [15:0] i2s_out,
  input  wire [15:0] i2s_oe,
  output wire [15:0] i2s_in,
  input  wire [3:0]  uart_out,
  input  wire [3:0]  uart_oe,
  output wire [3:0]  uart_in,
  input  wire [11:0] mmc_out,
  input  wire [11:0] mmc_oe,
  output wire [11:0] mmc_in,
  input  wire [5:0]  external_memory_interface_addr_out,
  input  wire [5:0]  external_memory_interface_addr_oe,
  input  wire [20:0] pp_pad_in,
  output wire [20:0] pp_pad_out,
  output wire [20:0] pp_pad_oe,
  input  wire [5:0]  sp0_pad_in,
  output wire [5:0]  sp0_pad_out,
  output wire [5:0]  sp0_pad_oe,
  input  wire [5:0]  sp1_pad_in,
  output wire [5:0]  sp1_pad_out,
  output wire [5:0]  sp1_pad_oe,
  input  wire [5:0]  addr_pad_in,
  output wire [5:0]  addr_pad_out,
  output wire [5:0]  addr_pad_oe,
  output wire        clock_output_slew,
  output wire        ext_memory_slew
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [15:0]            bus_pin_selection_r;
  reg  [15:0]            slew_rate_control_r;
  reg  [15:0]            rdata_r;
  reg  [`PAD_N-1:0]      pad_meta_r;
  reg  [`PAD_N-1:0]      pad_sync_r;
  reg  [`PAD_N-1:0]      pad_out_r;
  reg  [`PAD_N-1:0]      pad_oe_r;
  reg  [`SRC_IN_N-1:0]   src_in_r;
  reg  [`PAD_N-1:0]      pad_out_nxt;
  reg  [`PAD_N-1:0]      pad_oe_nxt;
  reg  [`SRC_IN_N-1:0]   src_in_nxt;
  reg  [15:0]            rdata_nxt;
  reg  [6:0]             sel [0:`PAD_N-1];
  integer                p;
  integer                q;
  integer                s;
  integer                t;

  wire [2:0]             pp_mode;
  wire [1:0]             sp1_mode;
  wire [1:0]             sp0_mode;
  wire [5:0]             addr_gpio_sel;
  wire [`SRC_N-1:0]      src_out;
  wire [`SRC_N-1:0]      src_oe;
  wire [`PAD_N-1:0]      pad_in;

  assign pp_mode       = bus_pin_selection_r[`PP_SEL_MSB:`PP_SEL_LSB];
  assign sp1_mode      = bus_pin_selection_r[`SP1_SEL_MSB:`SP1_SEL_LSB];
  assign sp0_mode      = bus_pin_selection_r[`SP0_SEL_MSB:`SP0_SEL_LSB];
  assign addr_gpio_sel = bus_pin_selection_r[`ADDR_SEL_MSB:`ADDR_SEL_LSB];
  assign src_out = {external_memory_interface_addr_out, mmc_out, uart_out, i2s_out, spi_out, gp_out};
  assign src_oe  = {external_memory_interface_addr_oe, mmc_oe, uart_oe, i2s_oe, spi_oe, gp_oe};
  assign pad_in  = {addr_pad_in, sp1_pad_in, sp0_pad_in, pp_pad_in};

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  always @* begin
    rdata_nxt = 16'h0000;
    if (bus_rd && bus_addr == `BUS_PIN_SELECTION_OFS) begin
      rdata_nxt = bus_pin_selection_r;
    end else if (bus_rd && bus_addr == `SLEW_RATE_CONTROL_OFS) begin
      rdata_nxt = slew_rate_control_r;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      bus_pin_selection_r <= `BUS_PIN_SELECTION_RST;
      slew_rate_control_r <= `SLEW_RATE_CONTROL_RST;
      rdata_r             <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
      if (bus_wr && bus_addr == `BUS_PIN_SELECTION_OFS) begin
        bus_pin_selection_r <= bus_wdata & `BUS_PIN_SELECTION_MASK;
      end else if (bus_wr && bus_addr == `SLEW_RATE_CONTROL_OFS) begin
        slew_rate_control_r <= bus_wdata & `SLEW_RATE_CONTROL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source selection per pad
  // ----------------------------------------------------------------------
  always @* begin
    t   = 0;
    for (p = 0; p < `PAD_N; p = p + 1) begin
      sel[p] = `SRC_NONE;
    end
    if (pp_mode == `PP_MODE1 || pp_mode == `PP_MODE6) begin
      for (q = 0; q < 3; q = q + 1) begin
        t = q;
        sel[q] = `SRC_SPI + t[6:0];
      end
      for (q = 3; q < 9; q = q + 1) begin
        t = q + 9;
        sel[q] = t[6:0];
      end
      for (q = 0; q < 4; q = q + 1) begin
        t = q + 3;
        sel[17 + q] = `SRC_SPI + t[6:0];
      end
    end
    for (q = 0; q < 4; q = q + 1) begin
      t = q;
      case (pp_mode)
        `PP_MODE1: begin
          sel[9 + q]  = `SRC_I2S2 + t[6:0];
          sel[13 + q] = `SRC_UART + t[6:0];
        end
        `PP_MODE2: begin
          t = (q < 3) ? q + 18 : q + 24;
          sel[9 + q]  = t[6:0];
          t = q + 28;
          sel[13 + q] = t[6:0];
        end
        `PP_MODE3: begin
          t = (q == 0) ? 0 : ((q == 1) ? 3 : q - 1);
          sel[9 + q]  = `SRC_SPI + t[6:0];
          t = q;
          sel[13 + q] = `SRC_I2S3 + t[6:0];
        end
        `PP_MODE4: begin
          sel[9 + q]  = `SRC_I2S2 + t[6:0];
          sel[13 + q] = `SRC_UART + t[6:0];
        end
        `PP_MODE5: begin
          sel[13 + q] = `SRC_UART + t[6:0];
          t = (q == 0) ? 0 : ((q == 1) ? 3 : q - 1);
          sel[9 + q]  = `SRC_SPI + t[6:0];
        end
        `PP_MODE6: begin
          sel[9 + q]  = `SRC_I2S2 + t[6:0];
          sel[13 + q] = `SRC_I2S3 + t[6:0];
        end
        default: begin
        end
      endcase
    end
    for (q = 0; q < 6; q = q + 1) begin
      t = q;
      case (sp0_mode)
        `SP_MODE0: sel[`PAD_SP0 + q] = `SRC_MMC0 + t[6:0];
        `SP_MODE1: sel[`PAD_SP0 + q] = (q < 4) ? `SRC_I2S0 + t[6:0] : t[6:0];
        `SP_MODE2: sel[`PAD_SP0 + q] = t[6:0];
        default:   sel[`PAD_SP0 + q] = `SRC_NONE;
      endcase
      t = q + 6;
      case (sp1_mode)
        `SP_MODE0: sel[`PAD_SP1 + q] = `SRC_MMC1 + idx_lo(q);
        `SP_MODE1: sel[`PAD_SP1 + q] = (q < 4) ? `SRC_I2S1 + idx_lo(q) : t[6:0];
        `SP_MODE2: sel[`PAD_SP1 + q] = t[6:0];
        default:   sel[`PAD_SP1 + q] = `SRC_NONE;
      endcase
      t = q + 21;
      sel[`PAD_ADDR + q] = addr_gpio_sel[q] ? t[6:0] : `SRC_EXTERNAL_MEMORY_INTERFACE + idx_lo(q);
    end
  end

  function [6:0] idx_lo;
    input integer n;
    reg [31:0] v;
    begin
      v      = n;
      idx_lo = v[6:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pad drive and input return
  // ----------------------------------------------------------------------
  always @* begin
    pad_out_nxt = {`PAD_N{1'b0}};
    pad_oe_nxt  = {`PAD_N{1'b0}};
    src_in_nxt  = {`SRC_IN_N{1'b0}};
    for (p = 0; p < `PAD_N; p = p + 1) begin
      if (sel[p] != `SRC_NONE) begin
        pad_out_nxt[p] = src_out[sel[p]];
        pad_oe_nxt[p]  = src_oe[sel[p]];
      end
    end
    for (s = 0; s < `SRC_IN_N; s = s + 1) begin
      for (p = 0; p < `PAD_N; p = p + 1) begin
        if (sel[p] == idx_lo(s)) begin
          src_in_nxt[s] = pad_sync_r[p];
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      pad_meta_r <= {`PAD_N{1'b0}};
      pad_sync_r <= {`PAD_N{1'b0}};
      pad_out_r  <= {`PAD_N{1'b0}};
      pad_oe_r   <= {`PAD_N{1'b0}};
      src_in_r   <= {`SRC_IN_N{1'b0}};
    end else begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
      pad_out_r  <= pad_out_nxt;
      pad_oe_r   <= pad_oe_nxt;
      src_in_r   <= src_in_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus_rdata    = rdata_r;
  assign pp_pad_out   = pad_out_r[`PAD_SP0-1:`PAD_PP];
  assign pp_pad_oe    = pad_oe_r[`PAD_SP0-1:`PAD_PP];
  assign sp0_pad_out  = pad_out_r[`PAD_SP1-1:`PAD_SP0];
  assign sp0_pad_oe   = pad_oe_r[`PAD_SP1-1:`PAD_SP0];
  assign sp1_pad_out  = pad_out_r[`PAD_ADDR-1:`PAD_SP1];
  assign sp1_pad_oe   = pad_oe_r[`PAD_ADDR-1:`PAD_SP1];
  assign addr_pad_out = pad_out_r[`PAD_N-1:`PAD_ADDR];
  assign addr_pad_oe  = pad_oe_r[`PAD_N-1:`PAD_ADDR];
  assign gp_in        = src_in_r[31:0];
  assign spi_in       = src_in_r[38:32];
  assign i2s_in       = src_in_r[54:39];
  assign uart_in      = src_in_r[58:55];
  assign mmc_in       = src_in_r[70:59];
  assign clock_output_slew = slew_rate_control_r[`CLOCK_OUTPUT_PIN_SLEW_BIT];
  assign ext_memory_slew   = slew_rate_control_r[`EXTERNAL_MEMORY_INTERFACE_SLEW_BIT];

endmodule

// *** test/external_bus_pin_select_sva.sv ***
`timescale 1ns/1ps
module external_bus_pin_select_sva (
  input wire        mclk,
  input wire        sys_rst,
  input wire [15:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [15:0] bus_rdata,
  input wire [31:0] gp_out,
  input wire [6:0]  spi_out,
  input wire [11:0] mmc_out,
  input wire [5:0]  external_memory_interface_addr_out,
  input wire [20:0] pp_pad_out,
  input wire [20:0] pp_pad_oe,
  input wire [5:0]  sp0_pad_out,
  input wire [5:0]  addr_pad_out,
  input wire        clock_output_slew,
  input wire        ext_memory_slew
);
  reg  [15:0] sel_r;
  wire [2:0]  pp_code = sel_r[14:12];
  wire [1:0]  sp0_code = sel_r[9:8];
  wire [5:0]  adr_sel = sel_r[5:0];
  wire [5:0]  gp_hi = gp_out[26:21];
  wire [2:0]  spi_lo = spi_out[2:0];
  wire [5:0]  mmc_lo = mmc_out[5:0];

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Shadow of the selection register, so routing can be predicted from the bus.
  always @(posedge mclk) begin
    if (sys_rst)
      sel_r <= 16'h0000;
    else if (bus_wr && bus_addr == 16'h1C00)
      sel_r <= bus_wdata & 16'h7F3F;
  end

  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_sel_read: assert property (bus_rd && bus_addr == 16'h1C00 |=> bus_rdata == $past(sel_r))
    else $error("selection readback wrong");
  a_slew_rsvd: assert property (bus_rd && bus_addr == 16'h1C16 |=> (bus_rdata & 16'hFFFA) == 0)
    else $error("slew reserved bits not zero");
  a_clk_slew: assert property (bus_wr && bus_addr == 16'h1C16 && bus_wdata[2] |-> ##[1:2] clock_output_slew)
    else $error("clock output slew not set");
  a_mem_slew: assert property (bus_wr && bus_addr == 16'h1C16 && !bus_wdata[0] |-> ##[1:2] !ext_memory_slew)
    else $error("memory slew not cleared");
  a_addr_route: assert property (!$past(sys_rst) |-> addr_pad_out == (($past(adr_sel) & $past(gp_hi)) | (~$past(adr_sel) & $past(external_memory_interface_addr_out))))
    else $error("address pad routing wrong");
  a_sp0_mmc: assert property (!$past(sys_rst) && $past(sp0_code) == 2'h0 |-> sp0_pad_out == $past(mmc_lo))
    else $error("serial 0 card routing wrong");
  a_pp_idle: assert property ($past(pp_code) == 3'h0 || $past(pp_code) == 3'h7 |-> pp_pad_oe == 21'h000000)
    else $error("parallel port driven in reserved mode");
  a_pp_spi: assert property (!$past(sys_rst) && ($past(pp_code) == 3'h1 || $past(pp_code) == 3'h6) |-> pp_pad_out[2:0] == $past(spi_lo))
    else $error("parallel port serial lanes wrong");
endmodule

bind external_bus_pin_select external_bus_pin_select_sva i_sva (
  .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .gp_out(gp_out),
  .spi_out(spi_out), .mmc_out(mmc_out), .external_memory_interface_addr_out(external_memory_interface_addr_out),
  .pp_pad_out(pp_pad_out), .pp_pad_oe(pp_pad_oe), .sp0_pad_out(sp0_pad_out),
  .addr_pad_out(addr_pad_out), .clock_output_slew(clock_output_slew),
  .ext_memory_slew(ext_memory_slew));

// *** test/external_bus_pin_select_bench.sv ***
`timescale 1ns/1ps
module external_bus_pin_select_bench;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [15:0] bus_addr = 16'h0000;
  reg  [15:0] bus_wdata = 16'h0000;
  reg         bus_wr = 1'b0;
  reg         bus_rd = 1'b0;
  reg  [31:0] gp_out = 32'hC3A5_5A3C;
  reg  [31:0] gp_oe = 32'h3C5A_A5C3;
  reg  [6:0]  spi_out = 7'h5B;
  reg  [6:0]  spi_oe = 7'h24;
  reg  [15:0] i2s_out = 16'hE71D;
  reg  [15:0] i2s_oe = 16'h18E2;
  reg  [3:0]  uart_out = 4'h9;
  reg  [3:0]  uart_oe = 4'h6;
  reg  [11:0] mmc_out = 12'hB4D;
  reg  [11:0] mmc_oe = 12'h4B2;
  reg  [5:0]  external_memory_interface_addr_out = 6'h2A;
  reg  [5:0]  external_memory_interface_addr_oe = 6'h15;
  reg  [20:0] pp_pad_in = 21'h000000;
  reg  [5:0]  sp0_pad_in = 6'h00;
  reg  [5:0]  sp1_pad_in = 6'h00;
  reg  [5:0]  addr_pad_in = 6'h00;
  reg  [15:0] sel;
  wire [15:0] bus_rdata;
  wire [31:0] gp_in;
  wire [6:0]  spi_in;
  wire [15:0] i2s_in;
  wire [3:0]  uart_in;
  wire [11:0] mmc_in;
  wire [20:0] pp_pad_out, pp_pad_oe;
  wire [5:0]  sp0_pad_out, sp0_pad_oe, sp1_pad_out, sp1_pad_oe, addr_pad_out, addr_pad_oe;
  wire        clock_output_slew;
  wire        ext_memory_slew;
  integer     num_errors = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  integer     k;

  external_bus_pin_select i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .gp_out(gp_out),
    .gp_oe(gp_oe), .gp_in(gp_in), .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in),
    .i2s_out(i2s_out), .i2s_oe(i2s_oe), .i2s_in(i2s_in), .uart_out(uart_out),
    .uart_oe(uart_oe), .uart_in(uart_in), .mmc_out(mmc_out), .mmc_oe(mmc_oe),
    .mmc_in(mmc_in), .external_memory_interface_addr_out(external_memory_interface_addr_out), .external_memory_interface_addr_oe(external_memory_interface_addr_oe),
    .pp_pad_in(pp_pad_in), .pp_pad_out(pp_pad_out), .pp_pad_oe(pp_pad_oe),
    .sp0_pad_in(sp0_pad_in), .sp0_pad_out(sp0_pad_out), .sp0_pad_oe(sp0_pad_oe),
    .sp1_pad_in(sp1_pad_in), .sp1_pad_out(sp1_pad_out), .sp1_pad_oe(sp1_pad_oe),
    .addr_pad_in(addr_pad_in), .addr_pad_out(addr_pad_out), .addr_pad_oe(addr_pad_oe),
    .clock_output_slew(clock_output_slew), .ext_memory_slew(ext_memory_slew));

  always #5 mclk = ~mclk;

  // Expected parallel-port lanes for one select code; undefined lanes stay zero.
  function [20:0] pp_map(input [2:0] c, input [31:0] g, input [6:0] s, input [15:0] i,
                         input [3:0] u);
    case (c)
      3'h1: pp_map = {s[6:3], u, i[11:8], g[17:12], s[2:0]};
      3'h2: pp_map = {4'h0, g[31:28], g[27], g[20:18], 9'h000};
      3'h3: pp_map = {4'h0, i[15:12], s[2], s[1], s[3], s[0], 9'h000};
      3'h4: pp_map = {4'h0, u, i[11:8], 9'h000};
      3'h5: pp_map = {4'h0, u, s[2], s[1], s[3], s[0], 9'h000};
      3'h6: pp_map = {s[6:3], i[15:12], i[11:8], g[17:12], s[2:0]};
      default: pp_map = 21'h000000;
    endcase
  endfunction

  function [5:0] sp_map(input [1:0] c, input [5:0] m, input [3:0] i, input [5:0] g);
    case (c)
      2'h0: sp_map = m;
      2'h1: sp_map = {g[5:4], i};
      2'h2: sp_map = g;
      default: sp_map = 6'h00;
    endcase
  endfunction

  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
    end
  endtask

  task rd(input [15:0] a, input [15:0] exp, input string name);
    begin
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      chk(name, exp, bus_rdata);
    end
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(16'h1C00, 16'h0000, "sel_reset");
    rd(16'h1C16, 16'h0005, "slew_reset");
    chk("slew_pins", 2'b11, {clock_output_slew, ext_memory_slew});
    rd(16'h1C02, 16'h0000, "unmapped");
    wr(16'h1C16, 16'hFFFA);
    rd(16'h1C16, 16'h0000, "slew_rsvd");
    chk("slew_low", 2'b00, {clock_output_slew, ext_memory_slew});
    wr(16'h1C16, 16'h0004);
    wr(16'h1C02, 16'hFFFF);
    rd(16'h1C16, 16'h0004, "slew_mix");
    rd(16'h1C00, 16'h0000, "sel_kept");
    chk("slew_mix_pins", 2'b10, {clock_output_slew, ext_memory_slew});
    // Every select code of every field, reserved bits set, pads checked one edge later.
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge mclk);
      gp_out <= {gp_out[30:0], gp_out[31]};
      i2s_out <= ~i2s_out;
      sel = {1'b1, k[2:0], k[1:0], ~k[1:0], 2'b11, k[2:0], ~k[2:0]};
      wr(16'h1C00, sel);
      @(posedge mclk);
      #1;
      chk("pp_out", pp_map(sel[14:12], gp_out, spi_out, i2s_out, uart_out), pp_pad_out);
      chk("pp_oe", pp_map(sel[14:12], gp_oe, spi_oe, i2s_oe, uart_oe), pp_pad_oe);
      chk("sp0_out", sp_map(sel[9:8], mmc_out[5:0], i2s_out[3:0], gp_out[5:0]), sp0_pad_out);
      chk("sp0_oe", sp_map(sel[9:8], mmc_oe[5:0], i2s_oe[3:0], gp_oe[5:0]), sp0_pad_oe);
      chk("sp1_out", sp_map(sel[11:10], mmc_out[11:6], i2s_out[7:4], gp_out[11:6]), sp1_pad_out);
      chk("sp1_oe", sp_map(sel[11:10], mmc_oe[11:6], i2s_oe[7:4], gp_oe[11:6]), sp1_pad_oe);
      chk("addr_out", (sel[5:0] & gp_out[26:21]) | (~sel[5:0] & external_memory_interface_addr_out), addr_pad_out);
      chk("addr_oe", (sel[5:0] & gp_oe[26:21]) | (~sel[5:0] & external_memory_interface_addr_oe), addr_pad_oe);
      rd(16'h1C00, sel & 16'h7F3F, "sel_read");
    end
    // Pad inputs return through the selected routing.
    wr(16'h1C00, 16'h203F);
    @(posedge mclk);
    pp_pad_in <= 21'h000200;
    sp0_pad_in <= 6'h2D;
    sp1_pad_in <= 6'h1E;
    addr_pad_in <= 6'h33;
    repeat (4) @(posedge mclk);
    #1;
    chk("mmc_in", {6'h1E, 6'h2D}, mmc_in);
    chk("gp_in_addr", 6'h33, gp_in[26:21]);
    chk("gp_in_pp", 3'h1, gp_in[20:18]);
    // bench stands in for software; peripherals idle while routing changes.
    wr(16'h1C00, 16'h5100);
    pp_pad_in <= 21'h015A00;
    repeat (4) @(posedge mclk);
    #1;
    chk("spi_in", 7'h07, spi_in);
    chk("uart_in", 4'hA, uart_in);
    chk("i2s_in", 16'h000D, i2s_in);
    chk("gp_in_sp0", 2'h2, gp_in[5:4]);
    end_sim;
  end
endmodule
